// ---- rtl/adsq_ctrl.sv ----
// Purpose: Sequencer, trigger and interrupt control of an 8-channel ADC
// Assumes: APB slave, converter core answers with a done pulse
// Notes: One access-phase cycle per APB transfer, no wait states
//
// Design decision made here: the APB interface to the registers.
`default_nettype none
module adsq_ctrl #(
  parameter int DATA_W = 8,
  parameter int CHANNELS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adsq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_input_pin,
  input wire logic timer_event,
  output adsq_pkg::adsq_conv_req_s conv_req,
  input wire adsq_pkg::adsq_conv_res_s conv_res,
  output logic analog_power_on,
  output logic irq_req,
  output logic [2:0] irq_priority_field,
  output logic word_select_bit
);
  import adsq_pkg::*;

  // Refuse widths the register map and decode cannot serve
  if (DATA_W != 8 || CHANNELS != 8) begin : g_param_guard
    $error("adsq_ctrl serves 8-bit data and 8 channels only");
  end

  logic [7:0] converter_control_reg;
  logic [7:0] adc_irq_control_reg;
  logic [7:0] adc_vector_reg;
  logic [7:0] limit_compare_status;
  logic [DATA_W-1:0] data_reg [CHANNELS];
  logic [DATA_W-1:0] low6_reg, low7_reg, up6_reg, up7_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  adsq_state_e state_reg;
  logic [2:0] chan_reg;
  logic pin_prev_reg, tmr_prev_reg;
  logic abort_reg, start_reg;

  logic [7:0] word_idx;
  logic setup_ph, wr_acc, addr_ok;
  logic ctrl_wr, irqc_wr, vec_wr, cmp_wr;
  logic pin_edge, tmr_edge, hw_trigger;
  logic seq_end, result_ok;
  logic up6_hit, low6_hit, up7_hit, low7_hit, window_hit;
  logic done_req, alarm_req;
  logic [2:0] first_channel_field;
  logic pin_trigger_enable, timer_event_trigger_enable, cont_mode;
  logic run_request_bit;

  // Word index decode; byte lanes [1:0] are ignored as APB words align
  assign word_idx = paddr[9:2];
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign addr_ok = (paddr[ADDR_W-1:10] == '0) &&
                   (word_idx >= DATA0_IDX);
  assign ctrl_wr = wr_acc && addr_ok && (word_idx == CTRL_IDX);
  assign irqc_wr = wr_acc && addr_ok && (word_idx == IRQC_IDX);
  assign vec_wr = wr_acc && addr_ok && (word_idx == VEC_IDX);
  assign cmp_wr = wr_acc && addr_ok && (word_idx == CMP_IDX);

  assign first_channel_field = converter_control_reg[7:CTRL_CH_LSB];
  assign pin_trigger_enable = converter_control_reg[CTRL_PIN_TRIG];
  assign timer_event_trigger_enable = converter_control_reg[CTRL_TMR_TRIG];
  assign analog_power_on = converter_control_reg[CTRL_POWER];
  assign cont_mode = converter_control_reg[CTRL_CONT];
  assign run_request_bit = converter_control_reg[CTRL_RUN];

  // Trigger edges; pin is active low so a falling edge starts
  assign pin_edge = pin_prev_reg && !trigger_input_pin &&
                    pin_trigger_enable;
  assign tmr_edge = !tmr_prev_reg && timer_event &&
                    timer_event_trigger_enable;
  assign hw_trigger = pin_edge || tmr_edge;

  // Edge history; reset to idle levels, and trigger enables reset low, so release gives no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= 1'b1;
      tmr_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= trigger_input_pin;
      tmr_prev_reg <= timer_event;
    end
  end

  // Result of the current conversion is usable only while waiting
  assign result_ok = (state_reg == ADSQ_WAIT) && conv_res.done &&
                     !ctrl_wr;
  assign seq_end = result_ok && (chan_reg == LAST_CH);

  // Control register; a trigger sets run and wins over the stop write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_control_reg <= CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        converter_control_reg <= pwdata[7:0];
      end else if (seq_end && !cont_mode) begin
        converter_control_reg[CTRL_RUN] <= 1'b0;
      end
      if (hw_trigger) begin
        converter_control_reg[CTRL_RUN] <= 1'b1;
      end
    end
  end

  // Sequencer; idle while powered down or stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADSQ_IDLE;
      chan_reg <= 3'h0;
    end else if (ctrl_wr || !analog_power_on) begin
      state_reg <= ADSQ_IDLE;
      chan_reg <= pwdata[7:CTRL_CH_LSB];
    end else begin
      unique case (state_reg)
        ADSQ_IDLE: begin
          chan_reg <= first_channel_field;
          if (run_request_bit || hw_trigger) begin
            state_reg <= ADSQ_ISSUE;
          end
        end
        ADSQ_ISSUE: begin
          state_reg <= ADSQ_WAIT;
        end
        ADSQ_WAIT: begin
          if (result_ok) begin
            if (chan_reg != LAST_CH) begin
              chan_reg <= chan_reg + 3'h1;
              state_reg <= ADSQ_ISSUE;
            end else if (cont_mode) begin
              chan_reg <= first_channel_field;
              state_reg <= ADSQ_ISSUE;
            end else begin
              state_reg <= ADSQ_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Stop write or power down also aborts a running conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      abort_reg <= (ctrl_wr || !analog_power_on) &&
                   (state_reg != ADSQ_IDLE);
      start_reg <= (state_reg == ADSQ_ISSUE) && !ctrl_wr &&
                   analog_power_on;
    end
  end

  // One assignment so the request word has a single driver
  assign conv_req = '{start: start_reg, abort: abort_reg,
                      channel: chan_reg};

  // Data registers, one per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < CHANNELS; i++) begin
        data_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (result_ok && chan_reg == 3'(i)) begin
          data_reg[i] <= conv_res.data;
        end else if (wr_acc && addr_ok && word_idx == DATA0_IDX + 8'(i)) begin
          data_reg[i] <= pwdata[DATA_W-1:0];
        end
      end
    end
  end

  // Threshold registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low6_reg <= '0;
      low7_reg <= '0;
      up6_reg <= '1;
      up7_reg <= '1;
    end else if (wr_acc && addr_ok) begin
      if (word_idx == LOW6_IDX) low6_reg <= pwdata[7:0];
      if (word_idx == LOW7_IDX) low7_reg <= pwdata[7:0];
      if (word_idx == UP6_IDX) up6_reg <= pwdata[7:0];
      if (word_idx == UP7_IDX) up7_reg <= pwdata[7:0];
    end
  end

  // Window checks of channels 6 and 7
  adsq_window #(.DATA_W(DATA_W)) u_win6 (
    .result(conv_res.data),
    .hit_valid(result_ok && chan_reg == WATCH_CH6),
    .upper_limit(up6_reg),
    .lower_limit(low6_reg),
    .above_hit(up6_hit),
    .below_hit(low6_hit)
  );
  adsq_window #(.DATA_W(DATA_W)) u_win7 (
    .result(conv_res.data),
    .hit_valid(result_ok && chan_reg == LAST_CH),
    .upper_limit(up7_reg),
    .lower_limit(low7_reg),
    .above_hit(up7_hit),
    .below_hit(low7_hit)
  );
  assign window_hit = up6_hit || low6_hit || up7_hit || low7_hit;

  // Compare status; a new hit wins over the clear so none is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_compare_status <= CMP_RST;
    end else begin
      if (irqc_wr && adc_irq_control_reg[IRQC_ALARM] &&
          !pwdata[IRQC_ALARM]) begin
        limit_compare_status[7:4] <= 4'h0;
      end else if (cmp_wr) begin
        limit_compare_status[7:4] <= pwdata[7:4];
      end
      if (cmp_wr) begin
        limit_compare_status[2:0] <= pwdata[2:0];
      end
      if (up7_hit) limit_compare_status[CMP_UP7] <= 1'b1;
      if (up6_hit) limit_compare_status[CMP_UP6] <= 1'b1;
      if (low7_hit) limit_compare_status[CMP_LOW7] <= 1'b1;
      if (low6_hit) limit_compare_status[CMP_LOW6] <= 1'b1;
    end
  end

  // Interrupt control; software may set flags too, hardware set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_irq_control_reg <= IRQC_RST;
    end else begin
      if (irqc_wr) begin
        adc_irq_control_reg <= pwdata[7:0];
        adc_irq_control_reg[IRQC_RSVD] <= 1'b1;
      end
      if (seq_end) begin
        adc_irq_control_reg[IRQC_DONE] <= 1'b1;
      end
      if (window_hit) begin
        adc_irq_control_reg[IRQC_ALARM] <= 1'b1;
      end
    end
  end

  // Requests: flag gated by its enable
  assign done_req = adc_irq_control_reg[IRQC_DONE] &&
                    adc_irq_control_reg[IRQC_DONE_EN];
  assign alarm_req = adc_irq_control_reg[IRQC_ALARM] &&
                     adc_irq_control_reg[IRQC_ALARM_EN];
  assign irq_req = done_req || alarm_req;
  assign irq_priority_field = adc_irq_control_reg[2:0];

  // Vector; word select follows the winning source, alarm first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_vector_reg <= VEC_RST;
    end else begin
      if (vec_wr) begin
        adc_vector_reg[7:2] <= pwdata[7:2];
      end
      if (alarm_req) begin
        adc_vector_reg[VEC_WSEL] <= 1'b0;
      end else if (done_req) begin
        adc_vector_reg[VEC_WSEL] <= 1'b1;
      end
      adc_vector_reg[0] <= 1'b0;
    end
  end
  assign word_select_bit = adc_vector_reg[VEC_WSEL];

  // Read data latched in setup so it comes from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      pslverr_reg <= !addr_ok;
      prdata_reg <= 32'h0000_0000;
      if (addr_ok) begin
        unique case (word_idx)
          LOW6_IDX: prdata_reg[7:0] <= low6_reg;
          LOW7_IDX: prdata_reg[7:0] <= low7_reg;
          UP6_IDX: prdata_reg[7:0] <= up6_reg;
          UP7_IDX: prdata_reg[7:0] <= up7_reg;
          CMP_IDX: prdata_reg[7:0] <= limit_compare_status;
          CTRL_IDX: prdata_reg[7:0] <= converter_control_reg;
          IRQC_IDX: prdata_reg[7:0] <= adc_irq_control_reg;
          VEC_IDX: prdata_reg[7:0] <= adc_vector_reg;
          default: prdata_reg[7:0] <= data_reg[word_idx[2:0]];
        endcase
      end
    end
  end

  // Slave answers in the first access cycle
  assign pready = psel && penable;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;
endmodule // adsq_ctrl
`default_nettype wire

// ---- rtl/adsq_pkg.sv ----
// Purpose: Shared constants and types of the converter sequencer block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register indices are word indices; byte address is four times
`default_nettype none
package adsq_pkg;
  localparam int ADDR_W = 12;
  // Register indices
  localparam logic [7:0] DATA0_IDX = 8'hf0;
  localparam logic [7:0] LOW6_IDX = 8'hf8;
  localparam logic [7:0] LOW7_IDX = 8'hf9;
  localparam logic [7:0] UP6_IDX = 8'hfa;
  localparam logic [7:0] UP7_IDX = 8'hfb;
  localparam logic [7:0] CMP_IDX = 8'hfc;
  localparam logic [7:0] CTRL_IDX = 8'hfd;
  localparam logic [7:0] IRQC_IDX = 8'hfe;
  localparam logic [7:0] VEC_IDX = 8'hff;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] IRQC_RST = 8'h0f;
  localparam logic [7:0] VEC_RST = 8'h02;
  localparam logic [7:0] CMP_RST = 8'h0f;
  // Control register fields
  localparam int CTRL_CH_LSB = 5;
  localparam int CTRL_PIN_TRIG = 4;
  localparam int CTRL_TMR_TRIG = 3;
  localparam int CTRL_POWER = 2;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_RUN = 0;
  // Interrupt control fields
  localparam int IRQC_DONE = 7;
  localparam int IRQC_ALARM = 6;
  localparam int IRQC_DONE_EN = 5;
  localparam int IRQC_ALARM_EN = 4;
  localparam int IRQC_RSVD = 3;
  // Vector register fields
  localparam int VEC_WSEL = 1;
  // Compare status fields
  localparam int CMP_UP7 = 7;
  localparam int CMP_UP6 = 6;
  localparam int CMP_LOW7 = 5;
  localparam int CMP_LOW6 = 4;
  localparam int CMP_ONE = 3;
  localparam logic [2:0] LAST_CH = 3'h7;
  localparam logic [2:0] WATCH_CH6 = 3'h6;

  // Request to the analog conversion core
  typedef struct packed {
    logic start;
    logic abort;
    logic [2:0] channel;
  } adsq_conv_req_s;

  // Answer from the analog conversion core
  typedef struct packed {
    logic done;
    logic [7:0] data;
  } adsq_conv_res_s;

  typedef enum logic [1:0] {
    ADSQ_IDLE,
    ADSQ_ISSUE,
    ADSQ_WAIT
  } adsq_state_e;
endpackage : adsq_pkg
`default_nettype wire

// ---- rtl/adsq_window.sv ----
// Purpose: Window compare of one watched channel result
// Assumes: Result valid for one cycle with its channel number
// Notes: Flags are raw hits; the caller makes them sticky
`default_nettype none
module adsq_window #(
  parameter int DATA_W = 8
) (
  input wire logic [DATA_W-1:0] result,
  input wire logic hit_valid,
  input wire logic [DATA_W-1:0] upper_limit,
  input wire logic [DATA_W-1:0] lower_limit,
  output logic above_hit,
  output logic below_hit
);
  // Upper includes equality, lower is strict
  assign above_hit = hit_valid && (result >= upper_limit);
  assign below_hit = hit_valid && (result < lower_limit);
endmodule // adsq_window
`default_nettype wire

// ---- test/adsq_core_model.sv ----
// Purpose: Behavioural conversion core that answers sequencer start pulses
// Assumes: One conversion at a time; an abort drops it with no late answer
// Notes: Result is base plus channel, so the bench can predict every value
`default_nettype none
module adsq_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire adsq_pkg::adsq_conv_req_s conv_req,
  input wire logic [7:0] base,
  input wire logic [3:0] dly,
  output adsq_pkg::adsq_conv_res_s conv_res
);
  timeunit 1ns;
  timeprecision 1ps;
  import adsq_pkg::*;
  logic busy;
  logic [3:0] cnt;
  logic [2:0] ch;
  // Delay taken at start, so one run mixes prompt and slow answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      ch <= 3'h0;
      conv_res <= '0;
    end else begin
      conv_res.done <= 1'b0;
      // Data toggles outside done so a stale value never looks valid
      conv_res.data <= ~conv_res.data;
      if (conv_req.abort) begin
        busy <= 1'b0;
      end else if (conv_req.start) begin
        busy <= 1'b1;
        cnt <= dly;
        ch <= conv_req.channel;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        conv_res.done <= 1'b1;
        conv_res.data <= base + {5'h00, ch};
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // adsq_core_model
`default_nettype wire

// ---- test/adsq_ctrl_monitor.sv ----
// Purpose: Port-level checker of the sequencer and interrupt control
// Assumes: Zero wait state APB; word select follows flags two edges on
// Notes: Watches design ports only, APB inputs included; bound from the bench top file
`default_nettype none
module adsq_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adsq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire adsq_pkg::adsq_conv_req_s conv_req,
  input wire logic analog_power_on,
  input wire logic irq_req,
  input wire logic [2:0] irq_priority_field,
  input wire logic word_select_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  import adsq_pkg::*;
  logic acc;
  logic wr_ctrl;
  logic wr_irqc;
  // Completed access phases decoded once for all properties
  assign acc = psel && penable;
  assign wr_ctrl = acc && pwrite && paddr == {2'b00, CTRL_IDX, 2'b00};
  assign wr_irqc = acc && pwrite && paddr == {2'b00, IRQC_IDX, 2'b00};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  power_follow_a: assert property (wr_ctrl |=>
    analog_power_on == $past(pwdata[CTRL_POWER])) else $error("power bit");
  prio_follow_a: assert property (wr_irqc |=>
    irq_priority_field == $past(pwdata[2:0])) else $error("priority");
  no_early_start_a: assert property (wr_ctrl |=> !conv_req.start)
    else $error("start right after control write");
  irq_masked_a: assert property (wr_irqc && pwdata[5:4] == 2'b00
    |=> !irq_req) else $error("masked request shown");
  sw_irq_a: assert property (wr_irqc && pwdata[7] && pwdata[5]
    |=> irq_req) else $error("software flag gave no request");
  wsel_done_a: assert property (wr_irqc && pwdata[7:4] == 4'ha
    |-> ##2 word_select_bit) else $error("word select not upper");
  wsel_alarm_a: assert property (wr_irqc && pwdata[6] && pwdata[4]
    |-> ##2 !word_select_bit) else $error("alarm not first");
  vec_low_zero_a: assert property (acc && !pwrite
    && paddr == {2'b00, VEC_IDX, 2'b00} |-> prdata[0] == 1'b0)
    else $error("vector bit zero set");
  cover property (conv_req.start && conv_req.channel == LAST_CH);
  cover property ($rose(irq_req));
  cover property (acc && pslverr);
endmodule // adsq_ctrl_monitor
`default_nettype wire

// ---- test/adsq_ctrl_tb_top.sv ----
// Purpose: Self-checking bench of the sequencer and interrupt control
// Assumes: Core model answers each start; APB driven at rising edges
// Notes: Random start channel, result base and core delay, fixed seed
`default_nettype none
module adsq_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adsq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pin, tev, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, analog_power_on, irq_req, word_select_bit;
  logic [2:0] irq_priority_field, first, p;
  logic [7:0] base, c;
  logic [3:0] dly;
  adsq_conv_req_s conv_req;
  adsq_conv_res_s conv_res;
  logic [2:0] chq[$];
  integer seed = 68271;
  int miscompares = 0;
  int check_count = 0;
  int n;
  int aborts = 0;
  // Case code: source, sequence expected, control bits 4:0
  logic [7:0] cases [7] = '{8'h25, 8'h74, 8'h44, 8'hac, 8'h94, 8'hbc,
    8'h01};
  adsq_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_input_pin(pin), .timer_event(tev), .conv_req(conv_req),
    .conv_res(conv_res), .analog_power_on(analog_power_on),
    .irq_req(irq_req), .irq_priority_field(irq_priority_field),
    .word_select_bit(word_select_bit));
  adsq_core_model i_core (.pclk(pclk), .presetn(presetn),
    .conv_req(conv_req), .base(base), .dly(dly), .conv_res(conv_res));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Log every channel handed to the core, in order, and count aborts
  always @(posedge pclk) begin
    if (conv_req.start === 1'b1) chq.push_back(conv_req.channel);
    if (conv_req.abort === 1'b1) aborts++;
  end
  function automatic int exp_len(input logic [2:0] f);
    return 8 - int'(f);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One transfer; an idle edge after it keeps psel from two writes at once
  task automatic apb(input logic wr, input logic [7:0] idx,
      input logic [7:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (pready !== 1'b1) miscompares++; // A missing answer is a failure
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Poll the flag register until the sequence done flag shows, bounded
  task automatic wait_done();
    int k;
    k = 0;
    rd = '0;
    while (rd[7] !== 1'b1 && k < 100) begin
      apb(1'b0, IRQC_IDX, 8'h00);
      k++;
    end
  endtask
  // Trigger pulses kept wider than a clock and far apart
  task automatic fire(input logic [1:0] src);
    if (src == 2'b01) pin <= 1'b0;
    if (src == 2'b10) tev <= 1'b1;
    repeat (3) @(posedge pclk);
    pin <= 1'b1;
    tev <= 1'b0;
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, tev, presetn} = '0;
    pin = 1'b1;
    paddr = '0;
    pwdata = '0;
    dly = 4'h0;
    base = 8'($random(seed) & 32'h7f);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_IDX, 8'h00);
    chk(rd, 32'h00);
    apb(1'b0, IRQC_IDX, 8'h00);
    chk(rd, 32'h0f);
    apb(1'b0, VEC_IDX, 8'h00);
    chk(rd, 32'h02);
    apb(1'b0, 8'h10, 8'h00);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    $display("reset values done");
    for (int i = 0; i < 7; i++) begin
      c = cases[i];
      first = (i == 0) ? LAST_CH : 3'($random(seed));
      dly <= 4'($random(seed));
      apb(1'b1, IRQC_IDX, 8'h07);
      chq.delete();
      apb(1'b1, CTRL_IDX, {first, c[4:0]});
      fire(c[7:6]);
      wait_done();
      chk(rd[7], c[5]);
      chk(chq.size(), c[5] ? exp_len(first) : 0);
      foreach (chq[k]) chk(32'(chq[k]), 32'(first) + k);
      if (c[5]) begin
        apb(1'b0, CTRL_IDX, 8'h00);
        chk(rd, {24'h0, first, c[4:1], 1'b0});
        apb(1'b0, DATA0_IDX + 8'h07, 8'h00);
        chk(rd, {24'h0, base + 8'h07});
      end
      chk(analog_power_on, c[2]);
      $display("start case %0d done", i);
    end
    first = 3'($random(seed));
    chq.delete();
    apb(1'b1, CTRL_IDX, {first, 5'b00111});
    n = 0;
    while (chq.size() <= exp_len(first) && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(chq[exp_len(first)]), 32'(first));
    // A stop write in mid-sequence must abort the core exactly once
    n = aborts;
    apb(1'b1, CTRL_IDX, 8'h04);
    chq.delete();
    repeat (30) @(posedge pclk);
    chk(chq.size(), 0);
    chk(aborts - n, 1);
    $display("continuous test done");
    apb(1'b1, LOW6_IDX, 8'h00);
    apb(1'b1, UP6_IDX, base + 8'h06);
    apb(1'b1, LOW7_IDX, base + 8'h08);
    apb(1'b1, UP7_IDX, 8'hff);
    apb(1'b1, IRQC_IDX, 8'h17);
    apb(1'b1, CTRL_IDX, 8'hc5);
    wait_done();
    chk(rd, 32'hdf);
    apb(1'b0, CMP_IDX, 8'h00);
    chk(rd, 32'h6f);
    chk(irq_req, 1'b1);
    chk(word_select_bit, 1'b0);
    apb(1'b1, IRQC_IDX, 8'h17);
    apb(1'b0, CMP_IDX, 8'h00);
    chk(rd, 32'h0f);
    chk(irq_req, 1'b0);
    $display("window test done");
    p = 3'($random(seed));
    apb(1'b1, IRQC_IDX, {5'b10100, p});
    chk(irq_req, 1'b1);
    chk(irq_priority_field, p);
    // Word select is registered one edge behind the request
    @(posedge pclk);
    chk(word_select_bit, 1'b1);
    apb(1'b1, IRQC_IDX, {5'b11110, p});
    @(posedge pclk);
    chk(word_select_bit, 1'b0);
    apb(1'b1, IRQC_IDX, 8'h00);
    apb(1'b1, VEC_IDX, 8'hff);
    apb(1'b0, VEC_IDX, 8'h00);
    chk(rd & 32'hfd, 32'hfc);
    $display("interrupt test done");
    conclude();
  end
endmodule // adsq_ctrl_tb_top
bind adsq_ctrl adsq_ctrl_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .conv_req(conv_req),
  .analog_power_on(analog_power_on), .irq_req(irq_req),
  .irq_priority_field(irq_priority_field),
  .word_select_bit(word_select_bit));
`default_nettype wire
